// [test/remote_link.sv]
// far-end serializer model driving the receive pair of the block
`timescale 1ns/1ns
module remote_link (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bench control
  input wire logic send_en,
  input wire logic [17:0] word,
  input wire logic break_frame,
  // receive pair of the block
  output logic [4:0] line_pos,
  output logic [4:0] line_neg
);
  logic [2:0] phase;
  logic [19:0] frame;
  // all ones hides the stop bit, so no word boundary can be found
  assign frame = break_frame ? 20'hFFFFF : {1'b0, word, 1'b1};
  // each group held two clocks; idle lines toggle so nothing stale looks valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= 3'h0;
      line_pos <= 5'h15;
      line_neg <= 5'h15;
    end else if (send_en) begin
      phase <= phase + 3'h1;
      line_pos <= frame[5 * phase[2:1] +: 5];
      line_neg <= ~frame[5 * phase[2:1] +: 5];
    end else begin
      phase <= 3'h0;
      line_pos <= ~line_pos;
      line_neg <= ~line_neg;
    end
  end
endmodule : remote_link

// [test/testbench.sv]
// self-checking bench for the framed serializer/deserializer
`timescale 1ns/1ns
`define check(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("BAD %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module testbench;
  logic clk = 1'b0;
  logic reset, hsel, hwrite, hready, hresp, tx_ref_clk, sync_req, ramp, send_en, break_frame;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, ref_cnt;
  logic [2:0] hsize;
  logic [17:0] tx_data, rword, rx_data;
  logic [4:0] sin_pos, sin_neg, serial_out_pos, serial_out_neg, serial_emph;
  logic serial_oe, rx_data_oe, rx_clk, rx_clk_oe, lock_indicator_n, irq;
  int fail_count = 0;
  int samples_checked = 0;

  // 100 MHz system clock
  always #5 clk = ~clk;

  // 80 ns reference; words change at its fall, well away from the rise
  always @(posedge clk) begin
    ref_cnt <= ref_cnt + 2'h1;
    if (ref_cnt == 2'h3) begin
      tx_ref_clk <= ~tx_ref_clk;
      if (tx_ref_clk && ramp) tx_data <= tx_data + 18'h1;
    end
  end

  serdes_start_stop_framer uut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .tx_ref_clk(tx_ref_clk), .tx_data(tx_data), .sync_req(sync_req),
    .serial_out_pos(serial_out_pos), .serial_out_neg(serial_out_neg),
    .serial_emph(serial_emph), .serial_oe(serial_oe),
    .serial_in_pos(sin_pos), .serial_in_neg(sin_neg),
    .rx_data(rx_data), .rx_data_oe(rx_data_oe), .rx_clk(rx_clk), .rx_clk_oe(rx_clk_oe),
    .lock_indicator_n(lock_indicator_n), .irq(irq)
  );

  remote_link far_end (
    .clk(clk), .reset(reset), .send_en(send_en), .word(rword),
    .break_frame(break_frame), .line_pos(sin_pos), .line_neg(sin_neg)
  );

  // one single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= we;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0, v);
  endtask : rd

  task automatic wait_lock;
    while (lock_indicator_n !== 1'b0) @(posedge clk);
  endtask : wait_lock

  task automatic rx_rise;
    while (rx_clk !== 1'b0) @(posedge clk);
    while (rx_clk !== 1'b1) @(posedge clk);
  endtask : rx_rise

  // eight groups of five, one per two clocks, bit 0 earliest
  task automatic capture(output logic [39:0] b, output logic [39:0] e);
    for (int i = 0; i < 8; i++) begin
      repeat (2) @(posedge clk);
      b[i*5 +: 5] = serial_out_pos;
      e[i*5 +: 5] = serial_emph;
    end
  endtask : capture

  // word alignment of the capture is unknown, so try every offset
  function automatic logic has_frame(input logic [39:0] b, input logic [19:0] f);
    has_frame = 1'b0;
    for (int k = 0; k < 20; k++) if (b[k +: 20] === f) has_frame = 1'b1;
  endfunction : has_frame

  task automatic t_regs;
    logic [31:0] v;
    rd(32'h0, v);
    `check("ctrl", 32'h1, v)
    rd(32'h4, v);
    `check("status", 1'b0, v[0])
    bus(1'b1, 32'hC, 32'h7, v);
    rd(32'hC, v);
    `check("irq_en", 32'h7, v)
    rd(32'h20, v);
    `check("unmapped", 32'h0, v)
    `check("hresp", 1'b0, hresp)
    bus(1'b1, 32'h0, 32'h0, v);
    repeat (4) @(posedge clk);
    `check("pwrdn oe", 2'b00, {serial_oe, rx_data_oe})
  endtask : t_regs

  task automatic t_tx(input logic [17:0] w, input logic pre);
    logic [39:0] b, e;
    logic [31:0] v;
    bus(1'b1, 32'h0, {29'h0, pre, 2'b01}, v);
    tx_data <= w;
    repeat (40) @(posedge clk);
    capture(b, e);
    `check("frame", 1'b1, has_frame(b, {1'b0, w, 1'b1}))
    `check("neg", ~serial_out_pos, serial_out_neg)
    `check("tx oe", 1'b1, serial_oe)
    `check("emph", pre ? (b[39:1] ^ b[38:0]) : 39'h0, e[39:1])
  endtask : t_tx

  task automatic t_loop;
    logic [31:0] v;
    logic [17:0] prev;
    // a word with one lone start/stop position cannot fake a boundary
    tx_data <= 18'h001FF;
    bus(1'b1, 32'h0, 32'h3, v);
    wait_lock();
    ramp <= 1'b1;
    `check("loop oe", 1'b0, serial_oe)
    rd(32'h8, v);
    `check("lock irq", 1'b1, v[0])
    `check("irq", 1'b1, irq)
    bus(1'b1, 32'h10, 32'h7, v);
    repeat (2) @(posedge clk);
    `check("irq clr", 1'b0, irq)
    // let the ramped words reach the receive bus first
    repeat (40) @(posedge clk);
    rx_rise();
    prev = rx_data;
    // one new word per reference cycle must come back in order
    repeat (6) begin
      rx_rise();
      `check("rx seq", prev + 18'h1, rx_data)
      prev = rx_data;
    end
    `check("rx oe", 2'b11, {rx_data_oe, rx_clk_oe})
    ramp <= 1'b0;
  endtask : t_loop

  task automatic t_remote;
    logic [31:0] v;
    int n;
    bus(1'b1, 32'h0, 32'h1, v);
    // lock on a word with a single boundary, then switch to a busy one
    rword <= 18'h00FFF;
    send_en <= 1'b1;
    // leaving loopback may cost a lock cycle first
    repeat (200) @(posedge clk);
    wait_lock();
    rword <= 18'h15A3C;
    repeat (40) @(posedge clk);
    rx_rise();
    `check("rx word", 18'h15A3C, rx_data)
    rd(32'h14, v);
    `check("rx reg", 32'h15A3C, v)
    bus(1'b1, 32'h10, 32'h7, v);
    break_frame <= 1'b1;
    n = 0;
    while (lock_indicator_n !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    `check("miss", 1'b1, n >= 24 && n <= 64)
    break_frame <= 1'b0;
    repeat (2) @(posedge clk);
    `check("oe lost", 2'b00, {rx_data_oe, rx_clk_oe})
    n = 2;
    while (lock_indicator_n !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    `check("hold off", 1'b1, n >= 72 && n <= 200)
    rd(32'h8, v);
    `check("loss irq", 2'b11, v[1:0])
    send_en <= 1'b0;
  endtask : t_remote

  task automatic t_train;
    logic [31:0] v;
    logic [39:0] b, e;
    time t0;
    // six ticks of request is not enough
    while (!(ref_cnt == 2'h3 && tx_ref_clk == 1'b0)) @(posedge clk);
    sync_req <= 1'b1;
    repeat (48) @(posedge clk);
    sync_req <= 1'b0;
    repeat (16) @(posedge clk);
    rd(32'h4, v);
    `check("short req", 1'b0, v[3])
    while (!(ref_cnt == 2'h3 && tx_ref_clk == 1'b0)) @(posedge clk);
    sync_req <= 1'b1;
    t0 = $time;
    repeat (64) @(posedge clk);
    sync_req <= 1'b0;
    capture(b, e);
    `check("train word", 1'b1, has_frame(b, {1'b0, 9'h000, 9'h1FF, 1'b1}))
    v = 32'h8;
    while (v[3] !== 1'b0) rd(32'h4, v);
    `check("train len", 1'b1, $time - t0 >= 82500 && $time - t0 <= 82800)
    rd(32'h8, v);
    `check("train irq", 1'b1, v[2])
  endtask : t_train

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // whole run is about 100 us, mostly the training burst
  initial begin
    #300000;
    fail_count++;
    test_done();
  end

  // main sequence
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tx_ref_clk = 1'b0;
    ref_cnt = 2'h0;
    tx_data = 18'h0;
    sync_req = 1'b0;
    ramp = 1'b0;
    send_en = 1'b0;
    break_frame = 1'b0;
    rword = 18'h0;
    repeat (2) @(posedge clk);
    `check("reset", 5'h01, {rx_clk, rx_clk_oe, rx_data_oe, serial_oe, lock_indicator_n})
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_tx(18'h2A5C3, 1'b0);
    t_tx(18'h30F1D, 1'b1);
    t_loop();
    t_remote();
    t_train();
    test_done();
  end
endmodule : testbench

// [verilog/serdes_start_stop_framer.sv]
// top: pin sync, receive alignment and lock, output gating, ahb registers
`timescale 1ns/1ns
`include "sf_params.svh"
module serdes_start_stop_framer
  import sf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // parallel transmit side
  input wire logic tx_ref_clk,
  input wire logic [17:0] tx_data,
  input wire logic sync_req,
  // serial transmit pair, five bits per group
  output logic [4:0] serial_out_pos,
  output logic [4:0] serial_out_neg,
  output logic [4:0] serial_emph,
  output logic serial_oe,
  // serial receive pair
  input wire logic [4:0] serial_in_pos,
  input wire logic [4:0] serial_in_neg,
  // parallel receive side
  output logic [17:0] rx_data,
  output logic rx_data_oe,
  output logic rx_clk,
  output logic rx_clk_oe,
  output logic lock_indicator_n,
  // interrupt
  output logic irq
);
  tx_link_if lk ();

  logic [29:0] pin_s1;
  logic [29:0] pin_s2;
  logic ref_d;
  logic [2:0] ctrl;
  logic [2:0] next_ctrl;
  logic [2:0] irq_stat;
  logic [2:0] next_irq_stat;
  logic [2:0] irq_en;
  logic [2:0] next_irq_en;
  logic [2:0] events;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_req;
  grp_t rx_in;
  grp_t rx_prev;
  logic rx_ph;
  logic samp_d;
  logic [24:0] hist;
  logic [1:0] gcnt;
  logic [1:0] cand_g;
  logic [2:0] cand_p;
  logic [1:0] hit_cnt;
  logic [1:0] miss_cnt;
  logic [3:0] hold_cnt;
  rx_state_t st;
  logic [4:0] ok;
  word_t pay [5];
  logic any_ok;
  logic [2:0] first_p;
  logic at_word;
  logic match;

  // every pin from the far side passes two flip-flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1 <= 30'h00000000;
      pin_s2 <= 30'h00000000;
    end else begin
      pin_s1 <= {tx_ref_clk, sync_req, tx_data, serial_in_pos, serial_in_neg};
      pin_s2 <= pin_s1;
    end
  end

  // reference edge finder, only reads the second stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_d <= 1'b0;
    end else begin
      ref_d <= pin_s2[29];
    end
  end

  // framer feed; word and rise travel the same two stages
  assign lk.ref_tick = pin_s2[29] & ~ref_d;
  assign lk.tx_word = pin_s2[27:10];
  assign lk.sync_req = pin_s2[28];
  assign lk.preemph_en = ctrl[`SF_CTRL_PRE];

  tx_framer u_tx (
    .clk (clk),
    .reset (reset),
    .lk (lk.tx)
  );

  // receive source: loopback skips the pins entirely
  assign rx_in = ctrl[`SF_CTRL_LOOP] ? lk.grp
                                     : (pin_s2[9:5] & ~pin_s2[4:0]);

  // group timing recovery: resync on each change, sample the second clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_prev <= 5'h00;
      rx_ph <= 1'b0;
    end else begin
      rx_prev <= rx_in;
      if (rx_in != rx_prev) begin
        rx_ph <= 1'b1;
      end else begin
        rx_ph <= ~rx_ph;
      end
    end
  end

  // retimed history, oldest bit at the bottom
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hist <= 25'h0000000;
      gcnt <= 2'h0;
      samp_d <= 1'b0;
    end else begin
      samp_d <= rx_ph;
      if (rx_ph) begin
        hist <= {rx_in, hist[24:5]};
        gcnt <= gcnt + 2'h1;
      end
    end
  end

  // start/stop check at each of five bit offsets
  genvar p;
  generate
    for (p = 0; p < `SF_GRP_W; p++) begin : g_off
      assign ok[p] = hist[p] & ~hist[p + 19];
      assign pay[p] = hist[p + 18 : p + 1];
    end
  endgenerate

  // lowest offset that frames; a repetitive payload may fake one
  always_comb begin
    any_ok = 1'b0;
    first_p = 3'h0;
    for (int k = `SF_GRP_W - 1; k >= 0; k--) begin
      if (ok[k]) begin
        any_ok = 1'b1;
        first_p = 3'(k);
      end
    end
  end

  assign at_word = samp_d && (gcnt == cand_g);
  assign match = at_word && ok[cand_p];

  // boundary hunt, lock and hold-off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= RX_HUNT;
      cand_g <= 2'h0;
      cand_p <= 3'h0;
      hit_cnt <= 2'h0;
      miss_cnt <= 2'h0;
      hold_cnt <= 4'h0;
    end else if (samp_d) begin
      unique case (st)
        RX_HUNT: begin
          if (match) begin
            hit_cnt <= hit_cnt + 2'h1;
            if (hit_cnt == `SF_LOCK_HITS) begin
              st <= RX_LOCK;
              miss_cnt <= 2'h0;
            end
          end else if ((at_word || hit_cnt == 2'h0) && any_ok) begin
            cand_g <= gcnt;
            cand_p <= first_p;
            hit_cnt <= 2'h1;
          end else if (at_word) begin
            hit_cnt <= 2'h0;
          end
        end
        RX_LOCK: begin
          if (match) begin
            miss_cnt <= 2'h0;
          end else if (at_word) begin
            miss_cnt <= miss_cnt + 2'h1;
            if (miss_cnt == `SF_LOSS_MISSES) begin
              st <= RX_HOLD;
              hold_cnt <= 4'h0;
            end
          end
        end
        RX_HOLD: begin
          if (at_word) begin
            hold_cnt <= hold_cnt + 4'h1;
            if (hold_cnt + 4'h1 == `SF_HOLD_WORDS) begin
              st <= RX_HUNT;
              hit_cnt <= 2'h0;
            end
          end
        end
        default: begin
          st <= RX_HUNT;
        end
      endcase
    end
  end

  // parallel word and recovered word clock, data changes at the fall
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_data <= 18'h00000;
      rx_clk <= 1'b0;
    end else if (samp_d && st == RX_LOCK) begin
      if (match) begin
        rx_data <= pay[cand_p];
      end
      if (gcnt == cand_g) begin
        rx_clk <= 1'b0;
      end else if (gcnt == cand_g + 2'h2) begin
        rx_clk <= 1'b1;
      end
    end else if (st != RX_LOCK) begin
      rx_clk <= 1'b0;
    end
  end

  // pin drivers and enables; reset leaves every driver off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_out_pos <= 5'h00;
      serial_out_neg <= 5'h00;
      serial_emph <= 5'h00;
      serial_oe <= 1'b0;
      rx_data_oe <= 1'b0;
      rx_clk_oe <= 1'b0;
      lock_indicator_n <= 1'b1;
    end else begin
      serial_out_pos <= lk.grp;
      serial_out_neg <= ~lk.grp;
      serial_emph <= lk.emph;
      serial_oe <= ctrl[`SF_CTRL_EN] & ~ctrl[`SF_CTRL_LOOP];
      rx_data_oe <= ctrl[`SF_CTRL_EN] & (st == RX_LOCK);
      rx_clk_oe <= ctrl[`SF_CTRL_EN] & (st == RX_LOCK);
      lock_indicator_n <= (st != RX_LOCK);
    end
  end

  // lock gained, lock lost, training finished
  assign events[`SF_IRQ_LOCK] = samp_d && st == RX_HUNT && match && hit_cnt == `SF_LOCK_HITS;
  assign events[`SF_IRQ_LOSS] = samp_d && st == RX_LOCK && at_word && !match
                                && miss_cnt == `SF_LOSS_MISSES;
  assign events[`SF_IRQ_TRAIN] = lk.train_done;

  // ahb write data phase lands here; reads see it the same cycle
  always_comb begin
    next_ctrl = ctrl;
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    if (wr_pend && wr_addr == `SF_A_CTRL) begin
      next_ctrl = hwdata[2:0];
    end
    if (wr_pend && wr_addr == `SF_A_IRQ_EN) begin
      next_irq_en = hwdata[2:0];
    end
    if (wr_pend && wr_addr == `SF_A_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~hwdata[2:0];
    end
    next_irq_stat = next_irq_stat | events; // set beats clear
  end

  // control and interrupt registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= `SF_CTRL_RESET;
      irq_en <= 3'h0;
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & next_irq_en);
    end
  end

  assign rd_req = hsel && hready && htrans[1] && !hwrite;

  // ahb address phase; zero wait states, always okay
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
      hrdata <= 32'h00000000;
      if (rd_req) begin
        case (haddr[7:0])
          `SF_A_CTRL: hrdata <= {29'h0, next_ctrl};
          `SF_A_STAT: hrdata <= {28'h0, lk.train_busy, st, ~lock_indicator_n};
          `SF_A_IRQ_STAT: hrdata <= {29'h0, next_irq_stat};
          `SF_A_IRQ_EN: hrdata <= {29'h0, next_irq_en};
          `SF_A_RX_WORD: hrdata <= {14'h0, rx_data};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  sequence s_lost;
    $fell(st == RX_LOCK);
  endsequence

  AST_LOCK_GAIN: assert property (@(posedge clk) disable iff (reset)
    $rose(st == RX_LOCK) |-> $past(hit_cnt) == 2'h3 && $past(match))
    else $error("lock without four aligned words");
  AST_LOSS_OUT: assert property (@(posedge clk) disable iff (reset)
    s_lost |=> lock_indicator_n && !rx_clk_oe && !rx_data_oe)
    else $error("outputs still driven after lock loss");
  AST_HOLD_MIN: assert property (@(posedge clk) disable iff (reset)
    $fell(st == RX_HOLD) |-> $past(hold_cnt) == 4'h8)
    else $error("lock hold-off too short");
  AST_RESET_OUT: assert property (@(posedge clk)
    reset |-> !rx_clk && !serial_oe) else $error("drivers active in reset");
  AST_PWRDN: assert property (@(posedge clk) disable iff (reset)
    !ctrl[`SF_CTRL_EN] |=> !serial_oe && !rx_data_oe)
    else $error("power-down left pins driven");
  AST_LOOP: assert property (@(posedge clk) disable iff (reset)
    ctrl[`SF_CTRL_LOOP] |=> !serial_oe) else $error("loopback drives the pair");
  AST_RXCLK_DATA: assert property (@(posedge clk) disable iff (reset)
    $rose(rx_clk) |-> $stable(rx_data) ##1 $stable(rx_data))
    else $error("receive word moved at clock rise");
endmodule : serdes_start_stop_framer

// [verilog/sf_params.svh]
// constants for the start/stop framed serializer/deserializer
`ifndef SF_PARAMS_SVH
`define SF_PARAMS_SVH
// Summary of operation
// - capture the whole 18-bit transmit word on every reference clock rise
// - reference clock is the word clock, one word per reference cycle
// - each payload gets start bit one and stop bit zero, twenty bits
// - serial bits leave at twenty per reference period, two per bit clock
// - payload bit zero leaves first among the data bits
// - transmit and receive latency fixed once the link is up
// - framing bits added and removed inside, partner sees 18 bits only
// - receiver recovers bit timing from the stream and retimes the data
// - receiver finds the word boundary from start/stop, outputs 18 bits
// - with preemphasis, first bit of each equal run carries a boost mark
// - loopback feeds the serial stream straight into the receiver
// - during reset recovered word clock low, serial pair high impedance
// - lock after four aligned words, drop after four misaligned, hunt again
// - after lock loss indicator inactive nine words, outputs high impedance
// - request held over six cycles sends 1026 words of nine ones, nine zeros
// - enable low powers down, serial pair and receive bus high impedance
`define SF_PAY_W 18
`define SF_FRAME_W 20
`define SF_GRP_W 5
`define SF_LAST_GRP 2'h3
`define SF_LOCK_HITS 2'h3
`define SF_LOSS_MISSES 2'h3
`define SF_HOLD_WORDS 4'h9
`define SF_REQ_ARM 3'h6
`define SF_REQ_SAT 3'h7
`define SF_TRAIN_WORDS 11'h402
`define SF_TRAIN_WORD 18'h001FF
`define SF_A_CTRL 8'h00
`define SF_A_STAT 8'h04
`define SF_A_IRQ_STAT 8'h08
`define SF_A_IRQ_EN 8'h0C
`define SF_A_IRQ_CLR 8'h10
`define SF_A_RX_WORD 8'h14
`define SF_CTRL_RESET 3'h1
`define SF_CTRL_EN 0
`define SF_CTRL_LOOP 1
`define SF_CTRL_PRE 2
`define SF_IRQ_LOCK 0
`define SF_IRQ_LOSS 1
`define SF_IRQ_TRAIN 2
`endif

// [verilog/sf_pkg.sv]
// types shared by the framer modules
package sf_pkg;
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_LOCK = 2'b01,
    RX_HOLD = 2'b10
  } rx_state_t;
  typedef logic [4:0] grp_t;
  typedef logic [17:0] word_t;
endpackage : sf_pkg

// [verilog/tx_framer.sv]
// transmit framing, serializer groups, preemphasis and training pattern
`timescale 1ns/1ns
`include "sf_params.svh"
module tx_framer
  import sf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link to the top
  tx_link_if.tx lk
);
  logic [19:0] frame;
  logic [1:0] gidx;
  logic half;
  logic [2:0] req_cnt;
  logic [10:0] train_left;
  logic [4:0] base;
  logic grp_load;
  grp_t next_grp;
  grp_t next_emph;
  word_t payload;

  // training pattern replaces the partner word while it runs
  assign lk.train_busy = (train_left != 11'h000);
  assign payload = lk.train_busy ? `SF_TRAIN_WORD : lk.tx_word;
  assign base = 5'(gidx + 2'h1) * 5'h05;

  // word capture and group stepping, two clocks per five-bit group
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame <= 20'h00000;
      gidx <= 2'h0;
      half <= 1'b0;
    end else if (lk.ref_tick) begin
      frame <= {1'b0, payload, 1'b1};
      gidx <= 2'h0;
      half <= 1'b0;
    end else begin
      half <= ~half;
      if (half && gidx != `SF_LAST_GRP) begin
        gidx <= gidx + 2'h1;
      end
    end
  end

  // next group: start bit and payload low bits lead
  always_comb begin
    grp_load = 1'b0;
    next_grp = lk.grp;
    if (lk.ref_tick) begin
      grp_load = 1'b1;
      next_grp = {payload[3:0], 1'b1};
    end else if (half && gidx != `SF_LAST_GRP) begin
      grp_load = 1'b1;
      next_grp = frame[base +: 5];
    end
  end

  // boost mark where a bit differs from the one before it
  genvar i;
  generate
    for (i = 0; i < `SF_GRP_W; i++) begin : g_emph
      if (i == 0) begin : g_first
        assign next_emph[i] = lk.preemph_en & (next_grp[0] ^ lk.grp[4]);
      end else begin : g_rest
        assign next_emph[i] = lk.preemph_en & (next_grp[i] ^ next_grp[i-1]);
      end
    end
  endgenerate

  // group and boost registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lk.grp <= 5'h00;
      lk.emph <= 5'h00;
    end else if (grp_load) begin
      lk.grp <= next_grp;
      lk.emph <= next_emph;
    end
  end

  // training request qualification and pattern length
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_cnt <= 3'h0;
      train_left <= 11'h000;
      lk.train_done <= 1'b0;
    end else begin
      lk.train_done <= 1'b0;
      if (lk.ref_tick) begin
        if (!lk.sync_req) begin
          req_cnt <= 3'h0;
        end else if (req_cnt != `SF_REQ_SAT) begin
          req_cnt <= req_cnt + 3'h1;
        end
        if (lk.sync_req && req_cnt == `SF_REQ_ARM && !lk.train_busy) begin
          train_left <= `SF_TRAIN_WORDS;
        end else if (lk.train_busy) begin
          train_left <= train_left - 11'h001;
          lk.train_done <= (train_left == 11'h001);
        end
      end
    end
  end

  sequence s_load;
    lk.ref_tick;
  endsequence

  AST_START_BIT: assert property (@(posedge clk) disable iff (reset)
    s_load |=> lk.grp[0] == 1'b1) else $error("start bit missing");
  AST_STOP_BIT: assert property (@(posedge clk) disable iff (reset)
    s_load ##1 (!lk.ref_tick)[*6] |=> lk.grp[4] == 1'b0) else $error("stop bit missing");
  AST_TRAIN_START: assert property (@(posedge clk) disable iff (reset)
    $rose(lk.train_busy) |-> $past(req_cnt) == 3'h6 && $past(lk.sync_req))
    else $error("training started without a long request");
endmodule : tx_framer

// [verilog/tx_link_if.sv]
// signals between the top and the transmit framer
`timescale 1ns/1ns
interface tx_link_if;
  import sf_pkg::*;
  logic ref_tick;
  word_t tx_word;
  logic sync_req;
  logic preemph_en;
  grp_t grp;
  grp_t emph;
  logic train_busy;
  logic train_done;
  modport top (output ref_tick, tx_word, sync_req, preemph_en,
               input grp, emph, train_busy, train_done);
  modport tx (input ref_tick, tx_word, sync_req, preemph_en,
              output grp, emph, train_busy, train_done);
endinterface : tx_link_if
